// ### edid_policy_map.vh
`ifndef EDID_POLICY_MAP_VH
`define EDID_POLICY_MAP_VH

// ----------------------------------------------------------------
// Register pages, selected by address bits 15:8
// ----------------------------------------------------------------
`define PG_IN_CFG    8'h01
`define PG_OUT_CFG   8'h02
`define PG_IN_STAT   8'h03
`define PG_OUT_STAT  8'h04
`define PG_LIB_BIT   15

// ----------------------------------------------------------------
// Input configuration fields
// ----------------------------------------------------------------
`define IC_SEL_LSB   0
`define IC_SEL_MSB   3
`define IC_DYN       4
`define IC_HDCP_EN   5
`define IC_ALLOW22   6
`define IC_LOAD      7
`define IC_RST       7'h60

// ----------------------------------------------------------------
// Output configuration and encryption levels
// ----------------------------------------------------------------
`define OM_AUTO      2'h0
`define OM_DEPENDS   2'h1
`define OM_ALWAYS    2'h2
`define OC_RST       2'h1
`define LVL_NONE     2'h0
`define LVL_14       2'h1
`define LVL_22       2'h2

// ----------------------------------------------------------------
// Identification image geometry and timing
// ----------------------------------------------------------------
`define EDID_LAST    8'hff
`define BASE_LAST    8'h7f
`define HPD_TIME_MS  2000
`define CLK_KHZ      250000

// ----------------------------------------------------------------
// Repeater topology limits
// ----------------------------------------------------------------
`define MAX_DEVS     6'h20
`define MAX_DEPTH    3'h4

`endif

// ### edid_port.v
`timescale 1ns/10ps
`default_nettype none

`include "edid_policy_map.vh"

module edid_port #(
	parameter HPD_W      = 29,
	parameter HPD_CYCLES = 500000000
) (
	// Clock, reset and enable.
	input  wire             mclk_i,
	input  wire             rst_i,
	input  wire             ce_i,
	// Staging write from the copy engine.
	input  wire             wr_i,
	input  wire [7:0]       wr_addr_i,
	input  wire [7:0]       wr_data_i,
	input  wire             commit_i,
	// Source-facing DDC read side.
	input  wire [7:0]       ddc_addr_i,
	input  wire             ddc_busy_i,
	output reg  [7:0]       ddc_data_o,
	// Status and presence line.
	output reg              pend_o,
	output reg              bank_o,
	output reg              sink_presence_line_o
);

	localparam [HPD_W-1:0] HPD_LOAD = HPD_CYCLES;

	// Two banks: base block plus one extension block each.
	reg  [7:0]       mem [0:511];
	reg  [HPD_W-1:0] hpd_cnt_q;

	// ----------------------------------------------------------------
	// Bank storage
	// ----------------------------------------------------------------

	// Writes land only in the bank the source is not reading.
	always @(posedge mclk_i) begin
		if (ce_i && wr_i)
			mem[{~bank_o, wr_addr_i}] <= wr_data_i;
	end

	// DDC data is registered from the live bank.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			ddc_data_o <= 8'h00;
		else if (ce_i)
			ddc_data_o <= mem[{bank_o, ddc_addr_i}];
	end

	// ----------------------------------------------------------------
	// Commit and presence pulse
	// ----------------------------------------------------------------

	// Atomic bank swap.
	// The swap waits for an idle DDC bus so a read never straddles old and new data.
	// Live change allowed.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_o               <= 1'b0;
			bank_o               <= 1'b0;
			hpd_cnt_q            <= {HPD_W{1'b0}};
			sink_presence_line_o <= 1'b1;
		end else if (ce_i) begin
			if (pend_o && !ddc_busy_i) begin
				pend_o    <= 1'b0;
				bank_o    <= ~bank_o;
				hpd_cnt_q <= HPD_LOAD;
			end else begin
				pend_o <= pend_o | commit_i;
				if (hpd_cnt_q != {HPD_W{1'b0}})
					hpd_cnt_q <= hpd_cnt_q - 1'b1;
			end
			sink_presence_line_o <= (hpd_cnt_q == {HPD_W{1'b0}}) &&
			                        !(pend_o && !ddc_busy_i);
		end
	end

endmodule

`default_nettype wire

// ### edid_hdcp_policy.v
// Behaviour
// - Each input owns an independent identification circuit.
// - Image is 128-byte base plus extension.
// - Change drops presence line for 2 s.
// - Changes accepted with powered source attached.
// - Captured display data kept after unplug.
// - Any stored or captured image selectable.
// - Dynamic mode follows valid replacement display.
// - No encryption to incapable sink: red.
// - Protection disabled: report input not capable.
// - Auto output, unprotected content: no encryption.
// - Encrypt only while video is active.
// - Version 2.2 sink always gets 2.2.
// - Type 0 may drop to 1.4.
// - Type 1 to 1.4 sink: red screen.
// - Downconversion needs depends-on-input output setting.
// - Enforce 32 devices, four repeater levels.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

`include "edid_policy_map.vh"

module edid_hdcp_policy #(
	parameter N_IN       = 4,
	parameter IN_W       = 2,
	parameter N_OUT      = 2,
	parameter OUT_W      = 1,
	parameter NUM_IMG    = 8,
	parameter IMG_W      = 3,
	parameter HPD_W      = 29,
	parameter HPD_CYCLES = `HPD_TIME_MS * `CLK_KHZ
) (
	// Clock, reset and enable.
	input  wire                 mclk_i,
	input  wire                 rst_i,
	input  wire                 ce_i,
	// Register port.
	input  wire [15:0]          reg_addr_i,
	input  wire [31:0]          reg_wdata_i,
	input  wire                 reg_wr_i,
	input  wire                 reg_rd_i,
	output reg  [31:0]          reg_rdata_o,
	// Source-facing side, one lane per input.
	input  wire [8*N_IN-1:0]    ddc_addr_i,
	input  wire [N_IN-1:0]      ddc_busy_i,
	output wire [8*N_IN-1:0]    ddc_data_o,
	output wire [N_IN-1:0]      sink_presence_line_o,
	output reg  [2*N_IN-1:0]    hdcp_cap_o,
	// Display image capture from the output DDC reader.
	input  wire                 cap_we_i,
	input  wire [OUT_W-1:0]     cap_out_i,
	input  wire [7:0]           cap_addr_i,
	input  wire [7:0]           cap_data_i,
	input  wire                 cap_done_i,
	// Per-output stream and sink state.
	input  wire [N_OUT-1:0]     sink_det_i,
	input  wire [N_OUT-1:0]     vid_active_i,
	input  wire [N_OUT-1:0]     str_enc_i,
	input  wire [N_OUT-1:0]     str_v22_i,
	input  wire [N_OUT-1:0]     str_type1_i,
	input  wire [2*N_OUT-1:0]   sink_cap_i,
	input  wire [3*N_OUT-1:0]   rpt_depth_i,
	input  wire [6*N_OUT-1:0]   rpt_count_i,
	// Per-output encryption decision.
	output reg  [2*N_OUT-1:0]   enc_level_o,
	output reg  [N_OUT-1:0]     red_screen_o
);

	localparam [3:0] S_IDLE   = 4'b0001;
	localparam [3:0] S_COPY   = 4'b0010;
	localparam [3:0] S_COMMIT = 4'b0100;
	localparam [3:0] S_WAIT   = 4'b1000;
	localparam [3:0] IMG_BASE = NUM_IMG;
	localparam [3:0] SEL_END  = NUM_IMG + N_OUT;

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------

	reg  [7:0]          lib_mem [0:NUM_IMG*256-1];
	reg  [7:0]          cap_mem [0:N_OUT*256-1];
	reg  [6:0]          in_cfg_q [0:N_IN-1];
	reg  [1:0]          out_cfg_q [0:N_OUT-1];
	reg  [N_OUT-1:0]    cap_valid_q;
	reg  [7:0]          cap_sum_q;
	reg  [N_OUT-1:0]    det_m_q;
	reg  [N_OUT-1:0]    det_q;
	reg  [N_OUT-1:0]    topo_q;
	reg  [N_IN-1:0]     pend_q;
	reg  [N_IN-1:0]     pend_d;
	reg  [3:0]          state_q;
	reg  [IN_W-1:0]     cur_q;
	reg  [3:0]          src_q;
	reg  [7:0]          byte_q;
	reg  [IN_W-1:0]     pick;
	reg  [N_IN-1:0]     set_req;
	reg  [N_IN-1:0]     clr_req;
	reg  [31:0]         rd_mux;
	reg  [2*N_OUT-1:0]  lvl_d;
	reg  [N_OUT-1:0]    red_d;
	reg  [N_OUT-1:0]    topo_d;
	reg  [1:0]          sinkc;
	reg  [1:0]          mode;
	reg                 need;
	reg                 bad;
	integer             k, ki, ks, kp, ko;

	wire [7:0]          page     = reg_addr_i[15:8];
	wire [7:0]          idx      = reg_addr_i[7:0];
	wire                lib_hit  = reg_addr_i[`PG_LIB_BIT] && (reg_addr_i[14:8] < NUM_IMG);
	wire [7:0]          cap_sum_n = (cap_addr_i == 8'h00 ? 8'h00 : cap_sum_q) + cap_data_i;
	wire                cap_ok   = cap_done_i && (cap_sum_q == 8'h00);
	wire [3:0]          src_off  = src_q - IMG_BASE;
	wire [7:0]          src_byte = (src_q < IMG_BASE) ?
	                               lib_mem[{src_q[IMG_W-1:0], byte_q}] :
	                               cap_mem[{src_off[OUT_W-1:0], byte_q}];
	wire [3:0]          pick_sel = in_cfg_q[pick][`IC_SEL_MSB:`IC_SEL_LSB];
	wire [N_IN-1:0]     port_pend;
	wire [N_IN-1:0]     port_bank;

	// ----------------------------------------------------------------
	// Image library and capture store
	// ----------------------------------------------------------------

	always @(posedge mclk_i) begin
		if (ce_i && reg_wr_i && lib_hit)
			lib_mem[{reg_addr_i[IMG_W+7:8], idx}] <= reg_wdata_i[7:0];
	end

	// Display capture store.
	// Nothing clears this store on unplug, so the last display stays selectable.
	always @(posedge mclk_i) begin
		if (ce_i && cap_we_i)
			cap_mem[{cap_out_i, cap_addr_i}] <= cap_data_i;
	end

	// One base-block checksum shared by all outputs, validity per output; a valid base sums to zero.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_sum_q   <= 8'h00;
			cap_valid_q <= {N_OUT{1'b0}};
		end else if (ce_i) begin
			if (cap_we_i && cap_addr_i <= `BASE_LAST)
				cap_sum_q <= cap_sum_n;
			if (cap_we_i && cap_addr_i == 8'h00)
				cap_valid_q[cap_out_i] <= 1'b0;
			else if (cap_done_i)
				cap_valid_q[cap_out_i] <= cap_ok;
		end
	end

	// Sink detect pins come from outside and pass two flip-flops.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			det_m_q <= {N_OUT{1'b0}};
			det_q   <= {N_OUT{1'b0}};
		end else if (ce_i) begin
			det_m_q <= sink_det_i;
			det_q   <= det_m_q;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (ki = 0; ki < N_IN; ki = ki + 1)
				in_cfg_q[ki] <= `IC_RST;
			for (ki = 0; ki < N_OUT; ki = ki + 1)
				out_cfg_q[ki] <= `OC_RST;
		end else if (ce_i && reg_wr_i) begin
			if (page == `PG_IN_CFG && idx < N_IN)
				in_cfg_q[idx[IN_W-1:0]] <= reg_wdata_i[6:0];
			if (page == `PG_OUT_CFG && idx < N_OUT)
				out_cfg_q[idx[OUT_W-1:0]] <= reg_wdata_i[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Load requests
	// ----------------------------------------------------------------

	// Dynamic reload on valid capture.
	// A request that lands in the cycle its flag clears survives: set wins.
	always @* begin
		set_req = {N_IN{1'b0}};
		for (ks = 0; ks < N_IN; ks = ks + 1) begin
			if (reg_wr_i && page == `PG_IN_CFG && idx == ks && reg_wdata_i[`IC_LOAD])
				set_req[ks] = 1'b1;
			if (cap_ok && in_cfg_q[ks][`IC_DYN] &&
			    in_cfg_q[ks][`IC_SEL_MSB:`IC_SEL_LSB] == IMG_BASE + cap_out_i)
				set_req[ks] = 1'b1;
		end
		pend_d = (pend_q & ~clr_req) | set_req;
	end

	// Lowest pending input is served first.
	always @* begin
		pick = {IN_W{1'b0}};
		for (kp = N_IN - 1; kp >= 0; kp = kp - 1)
			if (pend_q[kp])
				pick = kp[IN_W-1:0];
	end

	// ----------------------------------------------------------------
	// Copy engine
	// ----------------------------------------------------------------

	// Request clear is taken when a copy starts, so a new load during a copy reruns it.
	always @* begin
		clr_req = {N_IN{1'b0}};
		if (state_q == S_IDLE && pend_q != {N_IN{1'b0}})
			clr_req[pick] = 1'b1;
	end

	// Base and extension copied.
	// One engine serves all inputs; loads are short next to a source's reread.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
			pend_q  <= {N_IN{1'b0}};
			cur_q   <= {IN_W{1'b0}};
			src_q   <= 4'h0;
			byte_q  <= 8'h00;
		end else if (ce_i) begin
			pend_q <= pend_d;
			case (state_q)
				S_IDLE: begin
					byte_q <= 8'h00;
					if (pend_q != {N_IN{1'b0}} && pick_sel < SEL_END) begin
						cur_q   <= pick;
						src_q   <= pick_sel;
						state_q <= S_COPY;
					end
				end
				S_COPY: begin
					byte_q <= byte_q + 8'h01;
					if (byte_q == `EDID_LAST)
						state_q <= S_COMMIT;
				end
				S_COMMIT: begin
					state_q <= S_WAIT;
				end
				S_WAIT: begin
					if (!port_pend[cur_q])
						state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Per-input identification circuits
	// ----------------------------------------------------------------

	genvar g;
	generate
		for (g = 0; g < N_IN; g = g + 1) begin : gen_in
			edid_port #(
				.HPD_W      (HPD_W),
				.HPD_CYCLES (HPD_CYCLES)
			) u_port (
				.mclk_i               (mclk_i),
				.rst_i                (rst_i),
				.ce_i                 (ce_i),
				.wr_i                 (state_q == S_COPY && cur_q == g),
				.wr_addr_i            (byte_q),
				.wr_data_i            (src_byte),
				.commit_i             (state_q == S_COMMIT && cur_q == g),
				.ddc_addr_i           (ddc_addr_i[8*g+7:8*g]),
				.ddc_busy_i           (ddc_busy_i[g]),
				.ddc_data_o           (ddc_data_o[8*g+7:8*g]),
				.pend_o               (port_pend[g]),
				.bank_o               (port_bank[g]),
				.sink_presence_line_o (sink_presence_line_o[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Protection policy
	// ----------------------------------------------------------------

	// One decision per output, from stream, sink and output setting.
	always @* begin
		lvl_d  = {2*N_OUT{1'b0}};
		red_d  = {N_OUT{1'b0}};
		topo_d = {N_OUT{1'b0}};
		sinkc  = 2'h0;
		mode   = 2'h0;
		need   = 1'b0;
		bad    = 1'b0;
		for (k = 0; k < N_OUT; k = k + 1) begin
			sinkc = sink_cap_i[2*k+:2];
			mode  = out_cfg_q[k];
			need  = str_enc_i[k] || (mode == `OM_ALWAYS && sinkc != `LVL_NONE);
			bad   = str_v22_i[k] && (rpt_depth_i[3*k+:3] >= `MAX_DEPTH ||
			                         rpt_count_i[6*k+:6] >= `MAX_DEVS);
			topo_d[k] = bad;
			if (!vid_active_i[k] || !need)
				lvl_d[2*k+:2] = `LVL_NONE;
			else if (bad)
				red_d[k] = 1'b1;
			else if (sinkc == `LVL_22)
				lvl_d[2*k+:2] = `LVL_22;
			else if (sinkc == `LVL_14) begin
				if (str_v22_i[k] && (str_type1_i[k] || mode != `OM_DEPENDS))
					red_d[k] = 1'b1;
				else
					lvl_d[2*k+:2] = `LVL_14;
			end else
				red_d[k] = 1'b1;
		end
	end

	// Decisions and advertised capability are registered outputs.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			enc_level_o  <= {2*N_OUT{1'b0}};
			red_screen_o <= {N_OUT{1'b0}};
			topo_q       <= {N_OUT{1'b0}};
			hdcp_cap_o   <= {2*N_IN{1'b0}};
		end else if (ce_i) begin
			enc_level_o  <= lvl_d;
			red_screen_o <= red_d;
			topo_q       <= topo_d;
			for (ko = 0; ko < N_IN; ko = ko + 1)
				hdcp_cap_o[2*ko+:2] <= !in_cfg_q[ko][`IC_HDCP_EN] ? `LVL_NONE :
				                       in_cfg_q[ko][`IC_ALLOW22] ? `LVL_22 : `LVL_14;
		end
	end

	// ----------------------------------------------------------------
	// Register readback
	// ----------------------------------------------------------------

	// Unmapped addresses read as zero.
	always @* begin
		rd_mux = 32'h0000_0000;
		if (lib_hit)
			rd_mux[7:0] = lib_mem[{reg_addr_i[IMG_W+7:8], idx}];
		else if (page == `PG_IN_CFG && idx < N_IN)
			rd_mux[6:0] = in_cfg_q[idx[IN_W-1:0]];
		else if (page == `PG_OUT_CFG && idx < N_OUT)
			rd_mux[1:0] = out_cfg_q[idx[OUT_W-1:0]];
		else if (page == `PG_IN_STAT && idx < N_IN)
			rd_mux[3:0] = {pend_q[idx[IN_W-1:0]], port_bank[idx[IN_W-1:0]],
			               port_pend[idx[IN_W-1:0]],
			               !sink_presence_line_o[idx[IN_W-1:0]]};
		else if (page == `PG_OUT_STAT && idx < N_OUT)
			rd_mux[5:0] = {topo_q[idx[OUT_W-1:0]], cap_valid_q[idx[OUT_W-1:0]],
			               det_q[idx[OUT_W-1:0]], red_screen_o[idx[OUT_W-1:0]],
			               enc_level_o[2*idx[OUT_W-1:0]+:2]};
	end

	// Read data stands only in the cycle after the strobe.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			reg_rdata_o <= 32'h0000_0000;
		else if (ce_i)
			reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
	end

endmodule

`default_nettype wire

// ### edid_hdcp_policy_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the encryption decision of output 0 and the presence line of input 0.
module edid_hdcp_policy_monitor #(
	parameter N_IN       = 4,
	parameter N_OUT      = 2,
	parameter HPD_CYCLES = 50
) (
	// Clock and reset.
	input wire               mclk_i,
	input wire               rst_i,
	input wire               ce_i,
	// Register read side.
	input wire               reg_rd_i,
	input wire [31:0]        reg_rdata_o,
	// Source side.
	input wire [N_IN-1:0]    ddc_busy_i,
	input wire [N_IN-1:0]    sink_presence_line_o,
	// Stream state and decision.
	input wire [N_OUT-1:0]   vid_active_i,
	input wire [N_OUT-1:0]   str_enc_i,
	input wire [N_OUT-1:0]   str_v22_i,
	input wire [N_OUT-1:0]   str_type1_i,
	input wire [2*N_OUT-1:0] sink_cap_i,
	input wire [3*N_OUT-1:0] rpt_depth_i,
	input wire [6*N_OUT-1:0] rpt_count_i,
	input wire [2*N_OUT-1:0] enc_level_o,
	input wire [N_OUT-1:0]   red_screen_o
);
	// Shorthands for output 0.
	wire        go0  = ce_i && vid_active_i[0] && str_enc_i[0];
	wire [1:0]  cap0 = sink_cap_i[1:0];
	wire [1:0]  lvl0 = enc_level_o[1:0];
	wire        topo = rpt_depth_i[2:0] < 3'h4 && rpt_count_i[5:0] < 6'h20;
	reg  [31:0] low_q;

	// Counts low cycles so that the whole hold time is judged when the line returns.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			low_q <= 32'h0000_0000;
		else if (!sink_presence_line_o[0])
			low_q <= low_q + 32'h0000_0001;
		else
			low_q <= 32'h0000_0000;
	end

	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	no_video_clear_a: assert property (ce_i && !vid_active_i[0] |=> lvl0 == 2'h0)
		else $error("encryption active without video");
	incapable_red_a: assert property (go0 && cap0 == 2'h0 |=> red_screen_o[0] && lvl0 == 2'h0)
		else $error("encrypted stream reached incapable sink");
	unenc_pass_a: assert property (ce_i && vid_active_i[0] && !str_enc_i[0] && cap0 == 2'h0
		|=> !red_screen_o[0] && lvl0 == 2'h0)
		else $error("plain stream blocked or encrypted");
	v22_sink_a: assert property (go0 && cap0 == 2'h2 && topo |=> lvl0 == 2'h2 && !red_screen_o[0])
		else $error("capable sink not given top level");
	type1_red_a: assert property (go0 && str_v22_i[0] && str_type1_i[0] && cap0 == 2'h1
		|=> red_screen_o[0])
		else $error("type 1 stream lowered");
	topo_limit_a: assert property (go0 && str_v22_i[0] && rpt_count_i[5:0] >= 6'h20
		|=> red_screen_o[0])
		else $error("device count limit ignored");
	red_clear_a: assert property (red_screen_o[0] |-> lvl0 == 2'h0)
		else $error("red screen with encryption");
	hold_time_a: assert property ($rose(sink_presence_line_o[0])
		|-> low_q == HPD_CYCLES || low_q == HPD_CYCLES + 1)
		else $error("presence low time wrong");
	atomic_swap_a: assert property (ce_i && ddc_busy_i[0] && sink_presence_line_o[0]
		|=> sink_presence_line_o[0])
		else $error("image swapped during a read");
	rdata_idle_a: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
		else $error("read data outside its cycle");

	// Main scenarios.
	cover property ($fell(sink_presence_line_o[0]));
	cover property (red_screen_o[0]);
	cover property (lvl0 == 2'h1);
endmodule

bind edid_hdcp_policy edid_hdcp_policy_monitor #(
	.N_IN(N_IN), .N_OUT(N_OUT), .HPD_CYCLES(HPD_CYCLES)
) u_monitor (.mclk_i, .rst_i, .ce_i, .reg_rd_i, .reg_rdata_o, .ddc_busy_i,
	.sink_presence_line_o, .vid_active_i, .str_enc_i, .str_v22_i, .str_type1_i,
	.sink_cap_i, .rpt_depth_i, .rpt_count_i, .enc_level_o, .red_screen_o);
`default_nettype wire

// ### edid_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// A source reading input 0 and a display handing its image to output 0.
module edid_far_side (
	// Clock.
	input  wire logic       mclk_i,
	// Source reader.
	input  wire logic [7:0] ddc_data_i,
	output logic [7:0]      ddc_addr_o,
	output logic            ddc_busy_o,
	// Display image capture.
	output logic            cap_we_o,
	output logic [7:0]      cap_addr_o,
	output logic [7:0]      cap_data_o,
	output logic            cap_done_o
);
	logic [7:0] got [256];

	// Everything idle at time zero.
	initial begin
		ddc_addr_o = 8'h00;
		ddc_busy_o = 1'b0;
		cap_we_o   = 1'b0;
		cap_addr_o = 8'h00;
		cap_data_o = 8'h00;
		cap_done_o = 1'b0;
	end

	// Reads the image reps times with busy held, one byte a cycle.
	task automatic src_read(input int reps);
		int i;
		for (i = 0; i <= 256 * reps; i++) begin
			@(posedge mclk_i);
			ddc_busy_o <= (i < 256 * reps);
			ddc_addr_o <= (i < 256 * reps) ? i[7:0] : ~ddc_addr_o;
			#1;
			if (i > 0)
				got[(i - 1) % 256] = ddc_data_i;
		end
	endtask

	// Sends a valid image whose bytes are index plus k; byte 127 balances the base block.
	task automatic capture(input logic [7:0] k);
		int i;
		logic [7:0] sum;
		sum = 8'h00;
		for (i = 0; i < 127; i++)
			sum = sum + i[7:0] + k;
		for (i = 0; i < 256; i++) begin
			@(posedge mclk_i);
			cap_we_o   <= 1'b1;
			cap_addr_o <= i[7:0];
			cap_data_o <= (i == 127) ? 8'h00 - sum : i[7:0] + k;
		end
		@(posedge mclk_i);
		cap_we_o   <= 1'b0;
		cap_done_o <= 1'b1;
		cap_data_o <= ~cap_data_o;
		@(posedge mclk_i);
		cap_done_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### edid_hdcp_policy_test.sv
`timescale 1ns/10ps
`default_nettype none
module edid_hdcp_policy_test;
	localparam int HPD = 50;
	logic        mclk_i      = 1'b0;
	logic        rst_i       = 1'b1;
	logic [15:0] reg_addr_i  = 16'h0000;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [7:0]  ddc_addr0;
	logic        ddc_busy0;
	logic [31:0] ddc_data_o;
	logic [3:0]  sink_presence_line_o;
	logic [7:0]  hdcp_cap_o;
	logic        cap_we;
	logic        cap_done;
	logic [7:0]  cap_addr;
	logic [7:0]  cap_data;
	logic [5:0]  st          = 6'h00;
	logic [2:0]  dep         = 3'h0;
	logic [5:0]  cnt         = 6'h00;
	logic        ce          = 1'b1;
	logic        cap_out     = 1'b0;
	logic [1:0]  det         = 2'h1;
	logic [3:0]  enc_level_o;
	logic [1:0]  red_screen_o;
	int          n_fail      = 0;
	int          n_compared  = 0;
	int          cycles      = 0;
	int          i;

	// Clock of 4 ns.
	always #2 mclk_i = ~mclk_i;

	edid_hdcp_policy #(.HPD_CYCLES(HPD)) u_dut (.mclk_i, .rst_i, .ce_i(ce), .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ddc_addr_i({24'h00_0000, ddc_addr0}),
		.ddc_busy_i({3'h0, ddc_busy0}), .ddc_data_o, .sink_presence_line_o, .hdcp_cap_o,
		.cap_we_i(cap_we), .cap_out_i(cap_out), .cap_addr_i(cap_addr), .cap_data_i(cap_data),
		.cap_done_i(cap_done), .sink_det_i(det), .vid_active_i({2{st[5]}}),
		.str_enc_i({2{st[4]}}), .str_v22_i({2{st[3]}}), .str_type1_i({2{st[2]}}),
		.sink_cap_i({2{st[1:0]}}), .rpt_depth_i({2{dep}}), .rpt_count_i({2{cnt}}),
		.enc_level_o, .red_screen_o);

	edid_far_side u_far (.mclk_i, .ddc_data_i(ddc_data_o[7:0]), .ddc_addr_o(ddc_addr0),
		.ddc_busy_o(ddc_busy0), .cap_we_o(cap_we), .cap_addr_o(cap_addr), .cap_data_o(cap_data),
		.cap_done_o(cap_done));

	task automatic end_sim;
		$display("Compared %0d values, %0d mismatches", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s is %h, not %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i   <= 1'b0;
		#1;
		check(reg_rdata_o & m, e, "register read");
	endtask

	task automatic wait_pres(input logic lvl);
		int n;
		for (n = 0; n < 1000 && sink_presence_line_o[0] !== lvl; n++)
			@(posedge mclk_i);
		check({31'h0000_0000, sink_presence_line_o[0]}, {31'h0000_0000, lvl}, "presence");
	endtask

	function automatic logic [7:0] img_byte(input logic [7:0] k, input int n);
		logic [7:0] s;
		int j;
		s = 8'h00;
		for (j = 0; j < 127; j++)
			s = s + j[7:0] + k;
		return (n == 127) ? 8'h00 - s : n[7:0] + k;
	endfunction

	task automatic img_chk(input logic [7:0] k);
		int n;
		for (n = 0; n < 256; n++)
			check({24'h00_0000, u_far.got[n]}, {24'h00_0000, img_byte(k, n)}, "image byte");
	endtask

	// Sets mode and stream state of output 0; e is {red, level}.
	task automatic pol(input logic [1:0] m, input logic [5:0] s, input logic [2:0] d,
		input logic [5:0] c, input logic [2:0] e);
		wr(16'h0200, {30'h0000_0000, m});
		@(posedge mclk_i);
		st  <= s;
		dep <= d;
		cnt <= c;
		repeat (2) @(posedge mclk_i);
		#1;
		check({29'h0000_0000, red_screen_o[0], enc_level_o[1:0]}, {29'h0000_0000, e}, "policy");
		rd(16'h0400, {29'h0000_0000, e}, 32'h0000_0007);
	endtask

	// Cuts a hang short.
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			$display("Error at %0t: run timed out", $time);
			end_sim();
		end
	end

	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(16'h0100, 32'h0000_0060);
		rd(16'h0200, 32'h0000_0001);
		wr(16'h0500, 32'h0000_00FF);
		rd(16'h0500, 32'h0000_0000);
		rd(16'h0400, 32'h0000_0008, 32'h0000_0008);
		rd(16'h0401, 32'h0000_0000, 32'h0000_0008);
		wr(16'h0101, 32'h0000_0040);
		repeat (2) @(posedge mclk_i);
		check({24'h00_0000, hdcp_cap_o}, 32'h0000_00A2, "capability");
		$display("register test done");
		for (i = 0; i < 256; i++)
			wr(16'h8000 + i[15:0], {24'h00_0000, img_byte(8'h30, i)});
		rd(16'h80FF, {24'h00_0000, img_byte(8'h30, 255)});
		wr(16'h0100, 32'h0000_00E0);
		u_far.src_read(2);
		wait_pres(1'b0);
		check({28'h000_0000, sink_presence_line_o}, 32'h0000_000E, "other inputs");
		rd(16'h0100, 32'h0000_0060);
		rd(16'h0300, 32'h0000_0005);
		wait_pres(1'b1);
		u_far.src_read(1);
		img_chk(8'h30);
		$display("library load test done");
		u_far.capture(8'h41);
		rd(16'h0400, 32'h0000_0010, 32'h0000_0010);
		wr(16'h0100, 32'h0000_00F8);
		wait_pres(1'b0);
		wait_pres(1'b1);
		u_far.src_read(1);
		img_chk(8'h41);
		u_far.capture(8'h07);
		wait_pres(1'b0);
		wait_pres(1'b1);
		u_far.src_read(1);
		img_chk(8'h07);
		$display("dynamic load test done");
		pol(2'h1, 6'b010010, 3'h0, 6'h00, 3'b000);
		pol(2'h1, 6'b110010, 3'h0, 6'h00, 3'b010);
		pol(2'h1, 6'b111010, 3'h3, 6'h1F, 3'b010);
		pol(2'h1, 6'b111010, 3'h4, 6'h00, 3'b100);
		pol(2'h1, 6'b111010, 3'h0, 6'h20, 3'b100);
		pol(2'h1, 6'b111001, 3'h0, 6'h00, 3'b001);
		pol(2'h0, 6'b111001, 3'h0, 6'h00, 3'b100);
		pol(2'h1, 6'b111101, 3'h0, 6'h00, 3'b100);
		pol(2'h1, 6'b110000, 3'h0, 6'h00, 3'b100);
		pol(2'h0, 6'b100000, 3'h0, 6'h00, 3'b000);
		pol(2'h2, 6'b100000, 3'h0, 6'h00, 3'b000);
		pol(2'h2, 6'b100001, 3'h0, 6'h00, 3'b001);
		pol(2'h0, 6'b110001, 3'h0, 6'h00, 3'b001);
		// With the enable low the decision must hold its last value.
		@(posedge mclk_i);
		ce <= 1'b0;
		st <= 6'b110000;
		repeat (3) @(posedge mclk_i);
		#1;
		check({29'h0000_0000, red_screen_o[0], enc_level_o[1:0]}, 32'h0000_0001, "frozen");
		@(posedge mclk_i);
		ce <= 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		check({29'h0000_0000, red_screen_o[0], enc_level_o[1:0]}, 32'h0000_0004, "resumed");
		$display("policy test done");
		end_sim();
	end
endmodule
`default_nettype wire
